// file: expv_defines.vh
/*
  Constants for the exception prioritizer and vectoring unit: handler
  addresses, vector offsets, cause codes, tlb reset values, counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef EXPV_DEFINES_VH
`define EXPV_DEFINES_VH

// fixed and base handler addresses
`define EXPV_RESET_VEC 32'hBFC00000
`define EXPV_DBG_VEC_EMU 32'hFF200200
`define EXPV_DBG_VEC_NOEMU 32'hBFC00480
`define EXPV_BASE_NORM_BEV0 32'h80000000
`define EXPV_BASE_NORM_BEV1 32'hBFC00200
`define EXPV_BASE_CERR_BEV0 32'hA0000000
`define EXPV_BASE_CERR_BEV1 32'hBFC00200
// vector offsets
`define EXPV_OFS_REFILL 32'h00000000
`define EXPV_OFS_CERR 32'h00000100
`define EXPV_OFS_GEN 32'h00000180
`define EXPV_OFS_IRQ 32'h00000200
// number of exception classes and class indices, 0 is highest priority
`define EXPV_NCLS 20
`define EXPV_C_COLD 0
`define EXPV_C_DBG 1
`define EXPV_C_WARM 2
`define EXPV_C_NMI 3
`define EXPV_C_IBERR 4
`define EXPV_C_IADE 5
`define EXPV_C_IREFILL 6
`define EXPV_C_IINV 7
`define EXPV_C_IWATCH 8
`define EXPV_C_ICERR 9
`define EXPV_C_IBUS 10
`define EXPV_C_INSTR 11
`define EXPV_C_DADE 12
`define EXPV_C_DREFILL 13
`define EXPV_C_DINV 14
`define EXPV_C_DMOD 15
`define EXPV_C_DCERR 16
`define EXPV_C_DWATCH 17
`define EXPV_C_DBUS 18
`define EXPV_C_IRQ 19
// cause exception codes
`define EXPV_EXC_INT 5'h00
`define EXPV_EXC_MOD 5'h01
`define EXPV_EXC_TLBL 5'h02
`define EXPV_EXC_TLBS 5'h03
`define EXPV_EXC_LOAD_FETCH_ADDRESS_ERROR_CODE 5'h04
`define EXPV_EXC_STORE_ADDRESS_ERROR_CODE 5'h05
`define EXPV_EXC_IBE 5'h06
`define EXPV_EXC_DBE 5'h07
`define EXPV_EXC_WATCH 5'h17
// tlb counts
`define EXPV_TLB_UPPER 5'h1F
`define EXPV_WIRED_RST 5'h00

`endif

// file: expv_unit.v
/*
  Exception prioritizer and vectoring unit. Ranks the pending exception
  classes, computes the handler address, and updates the status, return
  pc, faulting address, cause and tlb/watch state that each exception
  touches. Assumes the pipeline presents its conditions synchronously,
  holds them until taken, and uses the instruction-boundary input to
  mark where precise exceptions and NMI may be accepted.
*/
`timescale 1ns/10ps
`include "expv_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// [RQ1] highest first: cold, debug, warm, NMI, imprecise bus, fetch-side group.
// [RQ2] then instruction, data-side group, and interrupt lowest.
// [RQ3] cold reset, warm reset and NMI always vector to 0xBFC00000.
// [RQ4] debug vectors to 0xFF200200 with emulator, else 0xBFC00480.
// [RQ5] other handlers: base 0x80000000 or 0xBFC00200 by boot vector bit.
// [RQ6] cache error base is 0xA0000000 or 0xBFC00200 by boot vector bit.
// [RQ7] offset 0x000 refill with level clear, 0x100 cache error, else 0x180.
// [RQ8] interrupts use 0x200 when separate vector set, else general offset.
// [RQ9] cold reset taken after power-on reset asserted then released.
// [RQ10] cold reset clears soft reset flag, sets error level and boot vector.
// [RQ11] cold reset loads random to bound, clears wired and watch enables.
// [RQ12] cold reset loads some configuration bits from boot mode stream.
// [RQ13] debug taken on emulator breakpoint or software debug breakpoint.
// [RQ14] warm reset follows its input, vectoring when input deasserts.
// [RQ15] warm reset resets bus and cache machines in any state.
// [RQ16] warm reset or NMI: error pc saved, three status flags set.
// [RQ17] NMI on asserting edge, ignoring level flags and interrupt enable.
// [RQ18] NMI only at instruction boundary; caches stay intact.
// [RQ19] address error: misaligned word, misaligned halfword, kernel from user.
// [RQ20] address error uses common vector, code tells load/fetch or store.
// [RQ21] address error captures faulting virtual address.
// [RQ22] return pc is faulting pc or preceding branch with delay flag set.
// [RQ23] only highest reported; lower ones signal later.
// [RQ24] general exception saves return pc only if level flag clear, sets it.
module expv_unit #(
  parameter CFG_W = 8,
  parameter TLB_W = 5
) (
  input wire clk,
  input wire rst_b,
  input wire power_on_reset_n,
  input wire warm_reset_n,
  input wire nmi_n,
  input wire emu_break,
  input wire emulator_attached,
  input wire separate_irq_vector_select,
  input wire global_irq_enable,
  input wire [CFG_W-1:0] boot_mode_stream,
  input wire at_boundary,
  input wire [31:0] pc,
  input wire [31:0] branch_pc,
  input wire in_delay_slot,
  input wire [31:0] mem_vaddr,
  input wire mem_valid,
  input wire mem_store,
  input wire [1:0] mem_size,
  input wire mem_unaligned_ok,
  input wire user_mode,
  input wire fetch_iberr,
  input wire fetch_refill,
  input wire fetch_invalid,
  input wire fetch_watch,
  input wire fetch_cerr,
  input wire fetch_bus,
  input wire instr_exc,
  input wire [4:0] instr_exc_code,
  input wire software_debug_breakpoint_instr,
  input wire data_refill,
  input wire data_invalid,
  input wire data_modified,
  input wire data_cerr,
  input wire data_watch,
  input wire data_bus,
  input wire irq_pending,
  input wire clear_exc_level,
  input wire clear_err_level,
  output reg exc_take_r,
  output reg [31:0] new_pc_r,
  output reg [4:0] exc_class_r,
  output reg [4:0] cause_exception_code_r,
  output reg delay_slot_flag_r,
  output reg [31:0] exception_return_pc_r,
  output reg [31:0] error_return_pc_r,
  output reg [31:0] faulting_virtual_address_r,
  output reg exc_level_r,
  output reg error_level_flag_r,
  output reg soft_reset_flag_r,
  output reg boot_vector_select_r,
  output reg [TLB_W-1:0] tlb_random_r,
  output reg [TLB_W-1:0] tlb_wired_r,
  output reg iwatch_en_r,
  output reg dwatch_load_en_r,
  output reg dwatch_store_en_r,
  output reg [CFG_W-1:0] config_boot_r,
  output reg bus_cache_reset_r
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // index of the lowest set bit, i.e. highest priority pending class
  function [4:0] expv_pick;
    input [`EXPV_NCLS-1:0] pend;
    integer i;
    begin
      expv_pick = 5'h1F;
      for (i = `EXPV_NCLS - 1; i >= 0; i = i - 1) begin
        if (pend[i]) begin
          expv_pick = i[4:0];
        end
      end
    end
  endfunction

  // general or cache error base by boot vector select
  function [31:0] expv_base;
    input boot_vector_select;
    input cerr;
    begin
      if (cerr) begin
        expv_base = boot_vector_select ? `EXPV_BASE_CERR_BEV1 : `EXPV_BASE_CERR_BEV0; // RQ6
      end else begin
        expv_base = boot_vector_select ? `EXPV_BASE_NORM_BEV1 : `EXPV_BASE_NORM_BEV0; // RQ5
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input edge and level tracking

  reg por_seen_r;
  reg warm_prev_r;
  reg nmi_prev_r;
  reg nmi_pend_r;
  reg cold_pend_r;
  reg warm_pend_r;
  reg [4:0] cls_nxt;
  reg take_nxt;
  wire cold_release;
  wire warm_release;
  wire nmi_edge;

  assign cold_release = por_seen_r && power_on_reset_n; // RQ9
  assign warm_release = warm_prev_r == 1'b0 && warm_reset_n; // RQ14
  assign nmi_edge = nmi_prev_r && !nmi_n; // RQ17

  // pending latches; a new event wins over the clear by taking
  always @(posedge clk) begin
    if (!rst_b) begin
      por_seen_r <= 1'b0;
      warm_prev_r <= 1'b1;
      nmi_prev_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      cold_pend_r <= 1'b0;
      warm_pend_r <= 1'b0;
    end else begin
      warm_prev_r <= warm_reset_n;
      nmi_prev_r <= nmi_n;
      if (!power_on_reset_n) begin
        por_seen_r <= 1'b1;
      end else begin
        por_seen_r <= 1'b0;
      end
      cold_pend_r <= cold_release || (cold_pend_r && !(take_nxt && cls_nxt == `EXPV_C_COLD));
      warm_pend_r <= warm_release || (warm_pend_r && !(take_nxt && cls_nxt == `EXPV_C_WARM));
      // NMI latched so it waits for a boundary; set wins over the take
      nmi_pend_r <= nmi_edge || (nmi_pend_r && !(take_nxt && cls_nxt == `EXPV_C_NMI)); // RQ17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address error detection

  reg adr_err;

  // misalignment and user access to kernel space
  always @* begin
    adr_err = 1'b0;
    if (mem_valid) begin
      // fetches are words too; the unaligned exemption covers loads and stores only
      if (mem_size[1] && mem_vaddr[1:0] != 2'h0 && !(mem_unaligned_ok && !mem_size[0])) begin
        adr_err = 1'b1; // RQ19
      end
      if (mem_size == 2'h1 && mem_vaddr[0]) begin
        adr_err = 1'b1; // RQ19
      end
      if (user_mode && mem_vaddr[31]) begin
        adr_err = 1'b1; // RQ19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prioritisation and vector selection

  reg [`EXPV_NCLS-1:0] pend;
  reg [31:0] vec_nxt;
  reg [4:0] code_nxt;
  wire fetch_adr;
  wire data_adr;

  // fetch addresses are word accesses, flagged by the store input low and size 3
  assign fetch_adr = adr_err && !mem_store && mem_size == 2'h3;
  assign data_adr = adr_err && !fetch_adr;

  // precise classes wait for a boundary; resets and debug break do not
  always @* begin
    pend = {`EXPV_NCLS{1'b0}};
    pend[`EXPV_C_COLD] = cold_pend_r; // RQ1
    pend[`EXPV_C_DBG] = emu_break || (software_debug_breakpoint_instr && at_boundary); // RQ13
    pend[`EXPV_C_WARM] = warm_pend_r; // RQ15
    pend[`EXPV_C_NMI] = nmi_pend_r && at_boundary; // RQ18
    pend[`EXPV_C_IBERR] = fetch_iberr;
    pend[`EXPV_C_IADE] = fetch_adr && at_boundary;
    pend[`EXPV_C_IREFILL] = fetch_refill && at_boundary;
    pend[`EXPV_C_IINV] = fetch_invalid && at_boundary;
    pend[`EXPV_C_IWATCH] = fetch_watch && iwatch_en_r && at_boundary;
    pend[`EXPV_C_ICERR] = fetch_cerr && at_boundary;
    pend[`EXPV_C_IBUS] = fetch_bus && at_boundary;
    pend[`EXPV_C_INSTR] = instr_exc && at_boundary; // RQ2
    pend[`EXPV_C_DADE] = data_adr && at_boundary;
    pend[`EXPV_C_DREFILL] = data_refill && at_boundary;
    pend[`EXPV_C_DINV] = data_invalid && at_boundary;
    pend[`EXPV_C_DMOD] = data_modified && at_boundary;
    pend[`EXPV_C_DCERR] = data_cerr && at_boundary;
    pend[`EXPV_C_DWATCH] = data_watch && (mem_store ? dwatch_store_en_r : dwatch_load_en_r)
      && at_boundary;
    pend[`EXPV_C_DBUS] = data_bus && at_boundary;
    pend[`EXPV_C_IRQ] = irq_pending && global_irq_enable && !exc_level_r
      && !error_level_flag_r && at_boundary;
    cls_nxt = expv_pick(pend); // RQ23
    take_nxt = |pend;
  end

  // handler address and cause code for the winning class
  always @* begin
    code_nxt = `EXPV_EXC_INT;
    vec_nxt = expv_base(boot_vector_select_r, 1'b0) + `EXPV_OFS_GEN; // RQ7
    case (cls_nxt)
      `EXPV_C_COLD, `EXPV_C_WARM, `EXPV_C_NMI: begin
        vec_nxt = `EXPV_RESET_VEC; // RQ3
      end
      `EXPV_C_DBG: begin
        vec_nxt = emulator_attached ? `EXPV_DBG_VEC_EMU : `EXPV_DBG_VEC_NOEMU; // RQ4
      end
      `EXPV_C_IREFILL, `EXPV_C_DREFILL: begin
        code_nxt = (cls_nxt == `EXPV_C_DREFILL && mem_store) ? `EXPV_EXC_TLBS : `EXPV_EXC_TLBL;
        if (!exc_level_r) begin
          vec_nxt = expv_base(boot_vector_select_r, 1'b0) + `EXPV_OFS_REFILL; // RQ7
        end
      end
      `EXPV_C_ICERR, `EXPV_C_DCERR: begin
        vec_nxt = expv_base(boot_vector_select_r, 1'b1) + `EXPV_OFS_CERR; // RQ6
      end
      `EXPV_C_IRQ: begin
        if (separate_irq_vector_select) begin
          vec_nxt = expv_base(boot_vector_select_r, 1'b0) + `EXPV_OFS_IRQ; // RQ8
        end
      end
      `EXPV_C_IADE: code_nxt = `EXPV_EXC_LOAD_FETCH_ADDRESS_ERROR_CODE; // RQ20
      `EXPV_C_DADE: code_nxt = mem_store ? `EXPV_EXC_STORE_ADDRESS_ERROR_CODE : `EXPV_EXC_LOAD_FETCH_ADDRESS_ERROR_CODE; // RQ20
      `EXPV_C_IINV: code_nxt = `EXPV_EXC_TLBL;
      `EXPV_C_DINV: code_nxt = mem_store ? `EXPV_EXC_TLBS : `EXPV_EXC_TLBL;
      `EXPV_C_DMOD: code_nxt = `EXPV_EXC_MOD;
      `EXPV_C_IWATCH, `EXPV_C_DWATCH: code_nxt = `EXPV_EXC_WATCH;
      `EXPV_C_IBUS, `EXPV_C_IBERR: code_nxt = `EXPV_EXC_IBE;
      `EXPV_C_DBUS: code_nxt = `EXPV_EXC_DBE;
      `EXPV_C_INSTR: code_nxt = instr_exc_code;
      default: code_nxt = `EXPV_EXC_INT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural state updates

  wire is_err_class;
  wire is_cerr;
  wire [31:0] restart_pc;

  assign is_cerr = cls_nxt == `EXPV_C_ICERR || cls_nxt == `EXPV_C_DCERR;
  assign is_err_class = cls_nxt == `EXPV_C_WARM || cls_nxt == `EXPV_C_NMI;
  // a delay-slot instruction restarts at its branch
  assign restart_pc = in_delay_slot ? branch_pc : pc; // RQ22

  // one exception taken per cycle; the rest stay pending for later
  always @(posedge clk) begin
    if (!rst_b) begin
      exc_take_r <= 1'b0;
      new_pc_r <= `EXPV_RESET_VEC;
      exc_class_r <= 5'h00;
      cause_exception_code_r <= `EXPV_EXC_INT;
      delay_slot_flag_r <= 1'b0;
      exception_return_pc_r <= 32'h00000000;
      error_return_pc_r <= 32'h00000000;
      faulting_virtual_address_r <= 32'h00000000;
      exc_level_r <= 1'b0;
      error_level_flag_r <= 1'b1;
      soft_reset_flag_r <= 1'b0;
      boot_vector_select_r <= 1'b1;
      tlb_random_r <= `EXPV_TLB_UPPER;
      tlb_wired_r <= `EXPV_WIRED_RST;
      iwatch_en_r <= 1'b0;
      dwatch_load_en_r <= 1'b0;
      dwatch_store_en_r <= 1'b0;
      config_boot_r <= {CFG_W{1'b0}};
      bus_cache_reset_r <= 1'b0;
    end else begin
      exc_take_r <= take_nxt;
      bus_cache_reset_r <= !warm_reset_n; // RQ15
      if (clear_exc_level) begin
        exc_level_r <= 1'b0;
      end
      if (clear_err_level) begin
        error_level_flag_r <= 1'b0;
      end
      if (take_nxt) begin
        new_pc_r <= vec_nxt;
        exc_class_r <= cls_nxt;
        if (cls_nxt == `EXPV_C_COLD) begin
          soft_reset_flag_r <= 1'b0; // RQ10
          error_level_flag_r <= 1'b1; // RQ10
          boot_vector_select_r <= 1'b1; // RQ10
          tlb_random_r <= `EXPV_TLB_UPPER; // RQ11
          tlb_wired_r <= `EXPV_WIRED_RST; // RQ11
          iwatch_en_r <= 1'b0; // RQ11
          dwatch_load_en_r <= 1'b0; // RQ11
          dwatch_store_en_r <= 1'b0; // RQ11
          config_boot_r <= boot_mode_stream; // RQ12
        end else if (is_err_class) begin
          error_return_pc_r <= restart_pc; // RQ16
          error_level_flag_r <= 1'b1; // RQ16
          soft_reset_flag_r <= 1'b1; // RQ16
          boot_vector_select_r <= 1'b1; // RQ16
        end else if (is_cerr) begin
          error_return_pc_r <= restart_pc;
          error_level_flag_r <= 1'b1;
        end else if (cls_nxt != `EXPV_C_DBG) begin
          cause_exception_code_r <= code_nxt;
          delay_slot_flag_r <= in_delay_slot; // RQ22
          if (!exc_level_r) begin
            exception_return_pc_r <= restart_pc; // RQ24
          end
          exc_level_r <= 1'b1; // RQ24
          if (cls_nxt == `EXPV_C_IADE || cls_nxt == `EXPV_C_DADE) begin
            faulting_virtual_address_r <= mem_vaddr; // RQ21
          end
        end
      end
    end
  end

endmodule // expv_unit

// file: epv_asserts.sv
/*
  Concurrent checks on the exception unit's ports.
  Assumes a bind onto expv_unit, one clock and a sync active-low reset.
*/
`timescale 1ns/10ps
module epv_asserts #(
  parameter CFG_W = 8,
  parameter TLB_W = 5
) (
  input wire clk,
  input wire rst_b,
  input wire power_on_reset_n,
  input wire emulator_attached,
  input wire separate_irq_vector_select,
  input wire [CFG_W-1:0] boot_mode_stream,
  input wire at_boundary,
  input wire [31:0] mem_vaddr,
  input wire mem_store,
  input wire exc_take_r,
  input wire [31:0] new_pc_r,
  input wire [4:0] exc_class_r,
  input wire [4:0] cause_exception_code_r,
  input wire [31:0] faulting_virtual_address_r,
  input wire error_level_flag_r,
  input wire soft_reset_flag_r,
  input wire boot_vector_select_r,
  input wire [TLB_W-1:0] tlb_random_r,
  input wire [TLB_W-1:0] tlb_wired_r,
  input wire iwatch_en_r,
  input wire dwatch_load_en_r,
  input wire dwatch_store_en_r,
  input wire [CFG_W-1:0] config_boot_r
);
  ////////////////////////////////////////
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reset_vector: assert property (
    exc_take_r && exc_class_r inside {5'h00, 5'h02, 5'h03} |-> new_pc_r == 32'hBFC00000)
    else $error("reset class off the fixed vector");
  a_debug_vector: assert property (
    exc_take_r && exc_class_r == 5'h01
    |-> new_pc_r == ($past(emulator_attached) ? 32'hFF200200 : 32'hBFC00480))
    else $error("debug vector wrong");
  a_cold_state: assert property (
    exc_take_r && exc_class_r == 5'h00 |-> error_level_flag_r && boot_vector_select_r
    && !soft_reset_flag_r && tlb_wired_r == '0 && tlb_random_r == {TLB_W{1'b1}}
    && !(iwatch_en_r | dwatch_load_en_r | dwatch_store_en_r)
    && config_boot_r == $past(boot_mode_stream))
    else $error("cold reset state wrong");
  a_warm_state: assert property (
    exc_take_r && exc_class_r inside {5'h02, 5'h03}
    |-> error_level_flag_r && soft_reset_flag_r && boot_vector_select_r)
    else $error("warm reset or nmi flags wrong");
  a_irq_vector: assert property (
    exc_take_r && exc_class_r == 5'h13 |-> new_pc_r ==
    (boot_vector_select_r ? 32'hBFC00200 : 32'h80000000)
    + ($past(separate_irq_vector_select) ? 32'h200 : 32'h180))
    else $error("interrupt vector wrong");
  a_addr_code: assert property (
    exc_take_r && exc_class_r == 5'h0C
    |-> cause_exception_code_r == ($past(mem_store) ? 5'h05 : 5'h04)
    && faulting_virtual_address_r == $past(mem_vaddr))
    else $error("address error code or address wrong");
  a_nmi_boundary: assert property (
    exc_take_r && exc_class_r == 5'h03 |-> $past(at_boundary))
    else $error("nmi taken off a boundary");
  // release of the power-on pin must lead to the cold take within a few edges
  a_cold_release: assert property (
    $rose(power_on_reset_n) |-> ##[1:4] exc_take_r && exc_class_r == 5'h00)
    else $error("no cold take after release");
endmodule // epv_asserts

bind expv_unit epv_asserts #(.CFG_W(CFG_W), .TLB_W(TLB_W)) u_chk (
  .clk, .rst_b, .power_on_reset_n, .emulator_attached, .separate_irq_vector_select,
  .boot_mode_stream, .at_boundary, .mem_vaddr, .mem_store, .exc_take_r, .new_pc_r,
  .exc_class_r, .cause_exception_code_r, .faulting_virtual_address_r, .error_level_flag_r,
  .soft_reset_flag_r, .boot_vector_select_r, .tlb_random_r, .tlb_wired_r, .iwatch_en_r,
  .dwatch_load_en_r, .dwatch_store_en_r, .config_boot_r
);

// file: epv_pipe_model.sv
/*
  Pipeline and pin model facing the exception unit.
  Assumes its tasks are called just after a rising edge.
*/
`timescale 1ns/10ps
module epv_pipe_model (
  input wire clk,
  input wire exc_take_r,
  input wire [31:0] new_pc_r,
  output logic power_on_reset_n,
  output logic warm_reset_n,
  output logic nmi_n,
  output logic emu_break,
  output logic at_boundary,
  output logic in_delay_slot,
  output logic [31:0] pc,
  output wire [31:0] branch_pc
);
  ////////////////////////////////////////
  // pins idle inactive, fetch starts at the reset vector
  initial begin
    power_on_reset_n = 1'h1;
    warm_reset_n = 1'h1;
    nmi_n = 1'h1;
    emu_break = 1'h0;
    at_boundary = 1'h1;
    in_delay_slot = 1'h0;
    pc = 32'hBFC00000;
  end
  assign branch_pc = pc - 32'h4;
  // a word per cycle; a take redirects fetch one cycle late, like a real pipe
  always @(posedge clk) pc <= exc_take_r ? new_pc_r : pc + 32'h4;
  // resets are held three cycles so the unit sees the low level for sure
  task cold;
    power_on_reset_n = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    power_on_reset_n = 1'h1;
  endtask
  task warm;
    warm_reset_n = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    warm_reset_n = 1'h1;
  endtask
  task nmi;
    nmi_n = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    nmi_n = 1'h1;
  endtask
  task brk;
    emu_break = 1'h1;
    @(posedge clk);
    #1;
    emu_break = 1'h0;
  endtask
endmodule // epv_pipe_model

// file: tb_exception_prioritizer_vectoring.sv
/*
  Self-checking bench for the exception unit with a pipeline model.
  Assumes boot vector select stays 1 after reset, so handlers sit high.
*/
`timescale 1ns/10ps
module tb_exception_prioritizer_vectoring;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic emulator_attached = 1'h0;
  logic separate_irq_vector_select = 1'h0;
  logic [31:0] mem_vaddr = 32'h0;
  logic mem_valid = 1'h0, mem_store = 1'h0, user_mode = 1'h0;
  logic [1:0] mem_size = 2'h2;
  logic software_debug_breakpoint_instr = 1'h0;
  logic clear_exc_level = 1'h0, clear_err_level = 1'h0;
  logic [19:0] cnd = 20'h0;
  logic [31:0] exp_epc;
  wire power_on_reset_n, warm_reset_n, nmi_n, emu_break, at_boundary, in_delay_slot;
  wire [31:0] pc, branch_pc, new_pc_r, exception_return_pc_r, faulting_virtual_address_r;
  wire [31:0] error_return_pc_r;
  wire exc_take_r, delay_slot_flag_r, exc_level_r, error_level_flag_r, bus_cache_reset_r;
  wire soft_reset_flag_r, boot_vector_select_r;
  wire [4:0] exc_class_r, cause_exception_code_r;
  int mismatches = 0;
  int cmp_count = 0;
  ////////////////////////////////////////
  always #2.5 clk = ~clk;
  // cnd is indexed by class; watch classes stay idle as their enables reset off
  expv_unit u_dut (
    .clk, .rst_b, .power_on_reset_n, .warm_reset_n, .nmi_n, .emu_break, .emulator_attached,
    .separate_irq_vector_select, .global_irq_enable(1'h1), .boot_mode_stream(8'hA5),
    .at_boundary, .pc, .branch_pc, .in_delay_slot, .mem_vaddr, .mem_valid, .mem_store,
    .mem_size, .mem_unaligned_ok(1'h0), .user_mode, .fetch_iberr(cnd[4]),
    .fetch_refill(cnd[6]), .fetch_invalid(cnd[7]), .fetch_watch(cnd[8]), .fetch_cerr(cnd[9]),
    .fetch_bus(cnd[10]), .instr_exc(cnd[11]), .instr_exc_code(5'h0D),
    .software_debug_breakpoint_instr, .data_refill(cnd[13]), .data_invalid(cnd[14]),
    .data_modified(cnd[15]), .data_cerr(cnd[16]), .data_watch(cnd[17]), .data_bus(cnd[18]),
    .irq_pending(cnd[19]), .clear_exc_level, .clear_err_level, .exc_take_r, .new_pc_r,
    .exc_class_r, .cause_exception_code_r, .delay_slot_flag_r, .exception_return_pc_r,
    .error_return_pc_r, .faulting_virtual_address_r, .exc_level_r, .error_level_flag_r,
    .soft_reset_flag_r, .boot_vector_select_r, .tlb_random_r(), .tlb_wired_r(),
    .iwatch_en_r(), .dwatch_load_en_r(), .dwatch_store_en_r(), .config_boot_r(),
    .bus_cache_reset_r
  );
  epv_pipe_model u_pm (
    .clk, .exc_take_r, .new_pc_r, .power_on_reset_n, .warm_reset_n, .nmi_n, .emu_break,
    .at_boundary, .in_delay_slot, .pc, .branch_pc
  );
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      mismatches++;
      $display("ERROR %s expected %h got %h", nm, ex, got);
    end
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  // bounded wait for a take, then drop every cause as the pipeline must
  task wait_take;
    int n;
    n = 0;
    while (exc_take_r !== 1'h1 && n < 20) begin
      step;
      n++;
    end
    cnd = 20'h0;
    software_debug_breakpoint_instr = 1'h0;
    mem_valid = 1'h0;
    chk("take", 1, exc_take_r);
  endtask
  task clr_lv;
    clear_exc_level = 1'h1;
    clear_err_level = 1'h1;
    step;
    clear_exc_level = 1'h0;
    clear_err_level = 1'h0;
  endtask
  // handler addresses with boot vector select 1: base 0xBFC00200 plus offset
  function logic [31:0] exp_vec(input int k, input logic iv, input logic exl);
    case (k)
      9, 16: exp_vec = 32'hBFC00300;
      6, 13: exp_vec = exl ? 32'hBFC00380 : 32'hBFC00200;
      19: exp_vec = iv ? 32'hBFC00400 : 32'hBFC00380;
      default: exp_vec = 32'hBFC00380;
    endcase
  endfunction
  ////////////////////////////////////////
  task t_cold;
    u_pm.cold;
    wait_take;
    chk("class", 0, exc_class_r);
    chk("vector", 32'hBFC00000, new_pc_r);
    chk("flags", 3'h6, {error_level_flag_r, boot_vector_select_r, soft_reset_flag_r});
    step;
  endtask
  // each class from 4 to 19 but 5, 8, 12 and 17 raised with the lower ones among them pending at once
  task t_prio;
    for (int iv = 0; iv < 2; iv++)
      for (int k = 4; k < 20; k++)
        if (k != 5 && k != 8 && k != 12 && k != 17) begin
          clr_lv;
          separate_irq_vector_select = iv[0];
          cnd = 20'hDEED0 & (20'hFFFFF << k);
          wait_take;
          chk("class", k, exc_class_r);
          chk("vector", exp_vec(k, iv[0], 1'h0), new_pc_r);
        end
  endtask
  task t_addr;
    clr_lv;
    u_pm.in_delay_slot = 1'h1;
    {mem_valid, mem_store, mem_size, mem_vaddr} = {2'h3, 2'h2, 32'h00001002};
    exp_epc = branch_pc;
    wait_take;
    chk("class", 12, exc_class_r);
    chk("code", 5'h05, cause_exception_code_r);
    chk("badaddr", 32'h00001002, faulting_virtual_address_r);
    chk("epc", exp_epc, exception_return_pc_r);
    chk("slot", 1, delay_slot_flag_r);
    chk("exl", 1, exc_level_r);
    step;
    u_pm.in_delay_slot = 1'h0;
    {mem_valid, mem_store, mem_size, mem_vaddr} = {2'h2, 2'h1, 32'h00001001};
    wait_take;
    chk("code", 5'h04, cause_exception_code_r);
    chk("epc", exp_epc, exception_return_pc_r);
    step;
    {mem_valid, mem_size, mem_vaddr, user_mode} = {1'h1, 2'h2, 32'h80000000, 1'h1};
    wait_take;
    chk("class", 12, exc_class_r);
    user_mode = 1'h0;
    step;
    // misaligned fetch: load/fetch code and the fetch-side class
    {mem_valid, mem_store, mem_size, mem_vaddr} = {2'h2, 2'h3, 32'h00002002};
    wait_take;
    chk("class", 5, exc_class_r);
    chk("code", 5'h04, cause_exception_code_r);
    chk("badaddr", 32'h00002002, faulting_virtual_address_r);
    step;
    cnd[6] = 1'h1;
    wait_take;
    chk("vector", exp_vec(6, 1'h0, 1'h1), new_pc_r);
    step;
  endtask
  task t_warm_nmi;
    u_pm.warm;
    chk("bcrst", 1, bus_cache_reset_r);
    wait_take;
    chk("class", 2, exc_class_r);
    chk("vector", 32'hBFC00000, new_pc_r);
    chk("flags", 3'h7, {error_level_flag_r, boot_vector_select_r, soft_reset_flag_r});
    // the model has moved one word on since the take sampled its pc
    chk("erpc", branch_pc, error_return_pc_r);
    chk("bcrst", 0, bus_cache_reset_r);
    step;
    u_pm.at_boundary = 1'h0;
    u_pm.nmi;
    chk("take", 0, exc_take_r);
    u_pm.at_boundary = 1'h1;
    wait_take;
    chk("class", 3, exc_class_r);
    chk("vector", 32'hBFC00000, new_pc_r);
    chk("erpc", branch_pc, error_return_pc_r);
    step;
  endtask
  task t_debug;
    for (int e = 0; e < 2; e++) begin
      emulator_attached = e[0];
      u_pm.brk;
      wait_take;
      chk("class", 1, exc_class_r);
      chk("vector", e ? 32'hFF200200 : 32'hBFC00480, new_pc_r);
      step;
    end
    software_debug_breakpoint_instr = 1'h1;
    wait_take;
    chk("class", 1, exc_class_r);
    step;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'h1;
    t_cold;
    t_prio;
    t_addr;
    t_warm_nmi;
    t_debug;
    tally_and_finish;
  end
  // the sequence needs well under a thousand cycles
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
endmodule // tb_exception_prioritizer_vectoring
